/* hw/upg_port.sv */
/*
  User port block: eight user lines with direction control, a port whose
  bit 2 is a spare handshake output, a falling-edge flag input with sticky
  status, enable and interrupt, and a system reset line, all behind an
  AXI4-Lite slave. Assumes one clock, synchronous active-high reset, and
  pins resolved outside from the out/oe pairs.
*/
// Function
// - A user line whose direction bit is 1 is driven as an output.
// - A user line whose direction bit is 0 is an input and is not driven.
// - The user data register reads input levels and sets output levels.
// - The user direction register sits two places above the user data register.
// - Only a high-to-low flag transition sets the flag status bit.
// - An enabled, set flag status bit raises the interrupt request.
// - With the flag disabled no interrupt rises, yet the status stays readable.
// - The handshake output is bit 2 of the second port, driven by its own registers.
// - Pulling the reset line low asks for a cold start; the line is also a reset output.
`timescale 1ns/100ps

`include "upg_consts.svh"

module upg_port (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`UPG_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`UPG_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [7:0]             userLineIn,
  output logic      [7:0]             userLineOut,
  output logic      [7:0]             userLineOe,
  input  wire logic [7:0]             handshakePortIn,
  output logic      [7:0]             handshakePortOut,
  output logic      [7:0]             handshakePortOe,
  input  wire logic                   flagInput,
  input  wire logic                   resetLineIn,
  output logic                        resetLineOut,
  output logic                        resetLineOe,
  output logic                        coldStartReq,
  output logic                        irq
);
  import upg_pkg::*;

  upg_state_t             s_q;
  upg_state_t             s_d;
  logic [`UPG_SYNC_W-1:0] pinsSync;
  logic [7:0]             ulIn;
  logic [7:0]             hsIn;
  logic                   flagSync;
  logic                   resetSync;
  logic                   flagFall;
  upg_sel_t               wrSel;
  upg_sel_t               rdSel;

  upg_sync u_sync (
    .clock   (clock),
    .rst     (rst),
    .pinsIn  ({resetLineIn, flagInput, handshakePortIn, userLineIn}),
    .pinsOut (pinsSync)
  );

  assign ulIn      = pinsSync[7:0];
  assign hsIn      = pinsSync[15:8];
  assign flagSync  = pinsSync[`UPG_SYNC_FLAG];
  assign resetSync = pinsSync[`UPG_SYNC_RESET];

  // word-aligned decode; misaligned addresses fall to none
  function automatic upg_sel_t decodeSel(input logic [`UPG_ADDR_W-1:0] a);
    upg_sel_t sel;
    sel = UPG_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[`UPG_ADDR_W-1:2])
        `UPG_IDX_HS_DATA:  sel = UPG_SEL_HS_DATA;
        `UPG_IDX_UL_DATA:  sel = UPG_SEL_UL_DATA;
        `UPG_IDX_HS_DIR:   sel = UPG_SEL_HS_DIR;
        `UPG_IDX_UL_DIR:   sel = UPG_SEL_UL_DIR;
        `UPG_IDX_IRQ_STAT: sel = UPG_SEL_STAT;
        `UPG_IDX_IRQ_CLR:  sel = UPG_SEL_CLR;
        `UPG_IDX_IRQ_EN:   sel = UPG_SEL_EN;
        default:           sel = UPG_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // inputs show pin levels, outputs show the latch
  function automatic logic [7:0] portView(input logic [7:0] pins,
                                          input logic [7:0] data,
                                          input logic [7:0] dir);
    return (pins & ~dir) | (data & dir);
  endfunction

  assign flagFall = s_q.flagPrev & ~flagSync;
  assign wrSel    = decodeSel(s_q.awAddr);
  assign rdSel    = decodeSel(araddr);

  always_comb begin
    s_d          = s_q;
    s_d.flagPrev = flagSync;
    s_d.resetOe  = 1'b0;
    s_d.coldReq  = ~resetSync;

    // response handshakes release the channel first
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
      s_d.wr     = UPG_WR_COLLECT;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    // address and data taken in either order
    if (s_q.awRdy && awvalid) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (s_q.wRdy && wvalid) begin
      s_d.wHeld  = 1'b1;
      s_d.wData  = wdata[7:0];
      s_d.wLane0 = wstrb[0];
    end

    if (s_q.wr == UPG_WR_COLLECT && s_q.awHeld && s_q.wHeld) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `UPG_RESP_OKAY;
      s_d.wr     = UPG_WR_RESP;
      case (wrSel)
        UPG_SEL_HS_DATA: if (s_q.wLane0) s_d.hsData = s_q.wData;
        UPG_SEL_UL_DATA: if (s_q.wLane0) s_d.ulData = s_q.wData;
        UPG_SEL_HS_DIR:  if (s_q.wLane0) s_d.hsDir = s_q.wData;
        UPG_SEL_UL_DIR:  if (s_q.wLane0) s_d.ulDir = s_q.wData;
        UPG_SEL_CLR: begin
          if (s_q.wLane0 && s_q.wData[`UPG_BIT_FLAG]) begin
            s_d.flagSt = 1'b0;
          end
        end
        UPG_SEL_EN:      if (s_q.wLane0) s_d.flagEn = s_q.wData[`UPG_BIT_FLAG];
        UPG_SEL_STAT:    s_d.bresp = `UPG_RESP_OKAY;
        default:         s_d.bresp = `UPG_RESP_SLVERR;
      endcase
    end

    // edge applied after the clear so a same-cycle edge is kept
    if (flagFall) begin
      s_d.flagSt = 1'b1;
    end

    if (s_q.arRdy && arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `UPG_RESP_OKAY;
      s_d.rdata  = 8'h00;
      case (rdSel)
        UPG_SEL_HS_DATA: s_d.rdata = portView(hsIn, s_q.hsData, s_q.hsDir);
        UPG_SEL_UL_DATA: s_d.rdata = portView(ulIn, s_q.ulData, s_q.ulDir);
        UPG_SEL_HS_DIR:  s_d.rdata = s_q.hsDir;
        UPG_SEL_UL_DIR:  s_d.rdata = s_q.ulDir;
        UPG_SEL_STAT:    s_d.rdata[`UPG_BIT_FLAG] = s_q.flagSt;
        UPG_SEL_CLR:     s_d.rdata = 8'h00;
        UPG_SEL_EN:      s_d.rdata[`UPG_BIT_FLAG] = s_q.flagEn;
        default:         s_d.rresp = `UPG_RESP_SLVERR;
      endcase
    end

    // one write and one read in flight at most
    s_d.awRdy = ~s_d.awHeld && (s_d.wr == UPG_WR_COLLECT);
    s_d.wRdy  = ~s_d.wHeld && (s_d.wr == UPG_WR_COLLECT);
    s_d.arRdy = ~s_d.rvalid;
    s_d.irq   = s_d.flagSt & s_d.flagEn;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q         <= '0;
      s_q.wr      <= UPG_WR_COLLECT;
      s_q.hsDir   <= `UPG_RST_DIR;
      s_q.ulDir   <= `UPG_RST_DIR;
      s_q.hsData  <= `UPG_RST_DATA;
      s_q.ulData  <= `UPG_RST_DATA;
      s_q.flagEn  <= `UPG_RST_EN;
      s_q.resetOe <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready          = s_q.awRdy;
  assign wready           = s_q.wRdy;
  assign arready          = s_q.arRdy;
  assign bvalid           = s_q.bvalid;
  assign bresp            = s_q.bresp;
  assign rvalid           = s_q.rvalid;
  assign rresp            = s_q.rresp;
  assign rdata            = {24'h000000, s_q.rdata};
  assign userLineOut      = s_q.ulData;
  assign userLineOe       = s_q.ulDir;
  assign handshakePortOut = s_q.hsData;
  assign handshakePortOe  = s_q.hsDir;
  // open-drain: only ever pulls low, while reset holds and one cycle after
  assign resetLineOut     = 1'b0;
  assign resetLineOe      = s_q.resetOe;
  assign coldStartReq     = s_q.coldReq;
  assign irq              = s_q.irq;

  a_ul_dir_drive: assert property (@(posedge clock) disable iff (rst)
    (s_q.wr == UPG_WR_COLLECT && s_q.awHeld && s_q.wHeld && s_q.wLane0
     && wrSel == UPG_SEL_UL_DIR) |=> (userLineOe == $past(s_q.wData)))
    else $error("user line enables do not follow direction write");

  a_ul_input_float: assert property (@(posedge clock) disable iff (rst)
    (userLineOe == 8'h00 && !(s_q.awHeld && s_q.wHeld)) |=> (userLineOe == 8'h00))
    else $error("input line became driven without a direction write");

  a_ul_read_mix: assert property (@(posedge clock) disable iff (rst)
    (arvalid && arready && rdSel == UPG_SEL_UL_DATA) |=>
      (rvalid && rdata[7:0] == (($past(ulIn) & ~$past(userLineOe))
                                | ($past(userLineOut) & $past(userLineOe)))))
    else $error("user data read does not mix pins and latch");

  a_ul_dir_addr: assert property (@(posedge clock) disable iff (rst)
    (arvalid && arready && araddr == {`UPG_IDX_UL_DATA + 16'h0002, 2'h0}) |=>
      (rresp == `UPG_RESP_OKAY && rdata[7:0] == $past(userLineOe)))
    else $error("direction register not two above user data");

  a_flag_fall_set: assert property (@(posedge clock) disable iff (rst)
    ($past(flagSync) && !flagSync) |=> s_q.flagSt)
    else $error("falling flag edge did not set status");

  a_flag_no_rise: assert property (@(posedge clock) disable iff (rst)
    (!s_q.flagSt && !flagFall) |=> !s_q.flagSt)
    else $error("flag status set without a falling edge");

  a_irq_enabled: assert property (@(posedge clock) disable iff (rst)
    (flagFall && s_q.flagEn && !(s_q.awHeld && s_q.wHeld)) |=> irq)
    else $error("enabled flag did not raise interrupt");

  a_irq_masked: assert property (@(posedge clock) disable iff (rst)
    (!s_q.flagEn && !(s_q.awHeld && s_q.wHeld)) |=> !irq)
    else $error("interrupt raised while flag disabled");

  a_hs_line_out: assert property (@(posedge clock) disable iff (rst)
    (s_q.wr == UPG_WR_COLLECT && s_q.awHeld && s_q.wHeld && s_q.wLane0
     && wrSel == UPG_SEL_HS_DATA) |=>
      (handshakePortOut[`UPG_BIT_HS_LINE] == $past(s_q.wData[`UPG_BIT_HS_LINE])))
    else $error("handshake bit did not follow port write");

  a_cold_start: assert property (@(posedge clock) disable iff (rst)
    $fell(resetSync) |=> coldStartReq [*1] ##0 !resetLineOe)
    else $error("low reset line did not request cold start");

  a_dir_reset: assert property (@(posedge clock)
    (!rst && $past(rst)) |-> (userLineOe == 8'h00 && handshakePortOe == 8'h00
                              && resetLineOe))
    else $error("ports not all inputs after reset");

endmodule

/* hw/upg_sync.sv */
/*
  Two-flop synchroniser for every pin level entering the user port block.
  Assumes its inputs may change at any time relative to clock.
*/
`timescale 1ns/100ps

`include "upg_consts.svh"

module upg_sync (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`UPG_SYNC_W-1:0] pinsIn,
  output logic      [`UPG_SYNC_W-1:0] pinsOut
);
  import upg_pkg::*;

  upg_sync_state_t s_q;
  upg_sync_state_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.first  = pinsIn;
    s_d.second = s_q.first;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinsOut = s_q.second;

endmodule

/* include/upg_consts.svh */
/*
  Register indices, bit positions, bus answers and reset values for the
  user port block. Assumes a 32-bit AXI4-Lite bus in which index n sits at
  byte address 4*n.
*/
`ifndef UPG_CONSTS_SVH
`define UPG_CONSTS_SVH

`define UPG_ADDR_W        18
`define UPG_IDX_HS_DATA   16'hdd00
`define UPG_IDX_UL_DATA   16'hdd01
`define UPG_IDX_HS_DIR    16'hdd02
`define UPG_IDX_UL_DIR    16'hdd03
`define UPG_IDX_IRQ_STAT  16'hdd04
`define UPG_IDX_IRQ_CLR   16'hdd05
`define UPG_IDX_IRQ_EN    16'hdd06

`define UPG_BIT_FLAG      0
`define UPG_BIT_HS_LINE   2

`define UPG_SYNC_W        18
`define UPG_SYNC_FLAG     16
`define UPG_SYNC_RESET    17

`define UPG_RESP_OKAY     2'h0
`define UPG_RESP_SLVERR   2'h2

`define UPG_RST_DIR       8'h00
`define UPG_RST_DATA      8'h00
`define UPG_RST_EN        1'h0

`endif

/* include/upg_pkg.sv */
/*
  Types shared by the user port block: channel states, register selects
  and the packed state record of the top module.
  Assumes upg_consts.svh for the widths it names.
*/
`include "upg_consts.svh"

package upg_pkg;

  typedef enum logic [1:0] {
    UPG_WR_COLLECT = 2'h1,
    UPG_WR_RESP    = 2'h2
  } upg_wr_t;

  typedef enum logic [7:0] {
    UPG_SEL_NONE    = 8'h01,
    UPG_SEL_HS_DATA = 8'h02,
    UPG_SEL_UL_DATA = 8'h04,
    UPG_SEL_HS_DIR  = 8'h08,
    UPG_SEL_UL_DIR  = 8'h10,
    UPG_SEL_STAT    = 8'h20,
    UPG_SEL_CLR     = 8'h40,
    UPG_SEL_EN      = 8'h80
  } upg_sel_t;

  typedef struct packed {
    upg_wr_t                wr;
    logic                   awRdy;
    logic                   wRdy;
    logic                   arRdy;
    logic                   awHeld;
    logic [`UPG_ADDR_W-1:0] awAddr;
    logic                   wHeld;
    logic [7:0]             wData;
    logic                   wLane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [7:0]             rdata;
    logic [7:0]             hsData;
    logic [7:0]             hsDir;
    logic [7:0]             ulData;
    logic [7:0]             ulDir;
    logic                   flagPrev;
    logic                   flagSt;
    logic                   flagEn;
    logic                   irq;
    logic                   resetOe;
    logic                   coldReq;
  } upg_state_t;

  typedef struct packed {
    logic [`UPG_SYNC_W-1:0] first;
    logic [`UPG_SYNC_W-1:0] second;
  } upg_sync_state_t;

endpackage

/* test/tb_user_port_gpio_with_edge_flag.sv */
/*
  Self-checking bench for the user port block: bus tasks note expected
  answers in queues, a monitor compares them. Assumes upg_port and the
  peripheral model.
*/
`timescale 1ns/100ps
`include "upg_consts.svh"
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_user_port_gpio_with_edge_flag;
  import upg_pkg::*;
  localparam logic [1:0] OK = `UPG_RESP_OKAY;
  localparam logic [1:0] ER = `UPG_RESP_SLVERR;
  logic        clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, flagInput, resetLineIn;
  logic        resetLineOut, resetLineOe, coldStartReq, irq, pullReset, flagLevel;
  logic        farInReset;
  logic [1:0]  wn;
  logic [9:0]  rn;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  userLineIn, userLineOut, userLineOe, hsIn, hsOut, hsOe, farUser, farHs;
  logic [7:0]  d, v, p;
  logic [1:0]  wq[$];
  logic [9:0]  rq[$];
  int          errors, testsRun;

  upg_port u_dut (.clock(clock), .rst(rst), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .userLineIn(userLineIn), .userLineOut(userLineOut),
    .userLineOe(userLineOe), .handshakePortIn(hsIn), .handshakePortOut(hsOut),
    .handshakePortOe(hsOe), .flagInput(flagInput), .resetLineIn(resetLineIn),
    .resetLineOut(resetLineOut), .resetLineOe(resetLineOe),
    .coldStartReq(coldStartReq), .irq(irq));
  upg_peripheral u_far (.userLineOut(userLineOut), .userLineOe(userLineOe),
    .handshakePortOut(hsOut), .handshakePortOe(hsOe), .resetLineOut(resetLineOut),
    .resetLineOe(resetLineOe), .farUser(farUser), .farHs(farHs), .pullReset(pullReset),
    .flagLevel(flagLevel), .userLineIn(userLineIn), .handshakePortIn(hsIn),
    .resetLineIn(resetLineIn), .flagInput(flagInput), .farInReset(farInReset));

  initial clock = 1'b0;
  always #50 clock = ~clock;

  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] dat, input logic [1:0] er);
    logic awDone, wDone;
    @(posedge clock);
    wq.push_back(er);
    awaddr  <= a;
    wdata   <= {24'h0, dat};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awDone = 1'b0;
    wDone  = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (awready && !awDone) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wDone) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [1:0] er, input logic [7:0] ed);
    @(posedge clock);
    rq.push_back({er, ed});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rready <= 1'b0;
  endtask

  // monitor: oldest note against each answer
  always @(posedge clock) begin
    if (bvalid && bready) begin
      if (wq.size() == 0) begin
        errors++;
        $display("wrong value bresp expected none seen %h", bresp);
      end else begin
        // pop once: the macro names its expected value twice
        wn = wq.pop_front();
        `CHK("bresp", wn, bresp)
      end
    end
    if (rvalid && rready) begin
      if (rq.size() == 0) begin
        errors++;
        $display("wrong value rdata expected none seen %h", rdata);
      end else begin
        rn = rq.pop_front();
        p  = rn[7:0];
        `CHK("rresp", rn[9:8], rresp)
        `CHK("rdata", {24'h0, p}, rdata)
      end
    end
  end

  task automatic finishTest;
    $display("checks %0d errors %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // whole run is well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    finishTest();
  end

  initial begin
    void'($urandom(32'h5113fb37));
    {awvalid, wvalid, bready, arvalid, rready, pullReset} = '0;
    {awaddr, araddr, wdata} = '0;
    {farUser, farHs} = '0;
    flagLevel = 1'b1;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1 `CHK("resetLineOe", 1'b1, resetLineOe)
    `CHK("resetLineOut", 1'b0, resetLineOut)
    `CHK("farInReset", 1'b1, farInReset)
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ba(`UPG_IDX_UL_DIR), OK, 8'h00);
    `CHK("resetLineOe", 1'b0, resetLineOe)
    `CHK("farInReset", 1'b0, farInReset)
    rd(ba(`UPG_IDX_HS_DIR), OK, 8'h00);
    `CHK("userLineOe", 8'h00, userLineOe)
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      v = 8'($urandom);
      farUser <= 8'($urandom);
      wr(ba(`UPG_IDX_UL_DIR), d, OK);
      wr(ba(`UPG_IDX_UL_DATA), v, OK);
      settle(4);
      `CHK("userLineOe", d, userLineOe)
      `CHK("userLineOut", v, userLineOut)
      rd(ba(`UPG_IDX_UL_DATA), OK, (v & d) | (farUser & ~d));
    end
    wr(ba(`UPG_IDX_HS_DIR), 8'h04, OK);
    wr(ba(`UPG_IDX_HS_DATA), 8'hff, OK);
    settle(4);
    `CHK("handshakePortOe", 8'h04, hsOe)
    `CHK("handshake line", 1'b1, hsOut[`UPG_BIT_HS_LINE])
    rd(ba(`UPG_IDX_HS_DATA), OK, 8'h04);
    wr(ba(`UPG_IDX_IRQ_EN), 8'h00, OK);
    @(posedge clock) flagLevel <= 1'b0;
    settle(4);
    rd(ba(`UPG_IDX_IRQ_STAT), OK, 8'h01);
    `CHK("irq", 1'b0, irq)
    @(posedge clock) flagLevel <= 1'b1;
    settle(4);
    wr(ba(`UPG_IDX_IRQ_CLR), 8'h01, OK);
    rd(ba(`UPG_IDX_IRQ_STAT), OK, 8'h00);
    wr(ba(`UPG_IDX_IRQ_EN), 8'h01, OK);
    settle(2);
    `CHK("irq", 1'b0, irq)
    @(posedge clock) flagLevel <= 1'b0;
    settle(4);
    `CHK("irq", 1'b1, irq)
    wr(ba(`UPG_IDX_IRQ_EN), 8'h00, OK);
    settle(2);
    `CHK("irq", 1'b0, irq)
    wr(ba(`UPG_IDX_IRQ_STAT), 8'h00, OK);
    rd(ba(`UPG_IDX_IRQ_STAT), OK, 8'h01);
    wr(ba(`UPG_IDX_IRQ_EN), 8'h01, OK);
    settle(2);
    `CHK("irq", 1'b1, irq)
    rd(ba(`UPG_IDX_IRQ_EN), OK, 8'h01);
    rd(ba(`UPG_IDX_IRQ_CLR), OK, 8'h00);
    wr(ba(`UPG_IDX_IRQ_CLR), 8'h01, OK);
    settle(2);
    `CHK("irq", 1'b0, irq)
    rd(ba(16'hdd07), ER, 8'h00);
    wr(ba(16'hdd07), 8'h55, ER);
    wr(ba(`UPG_IDX_UL_DATA) + 18'h1, 8'h55, ER);
    @(posedge clock) pullReset <= 1'b1;
    settle(4);
    `CHK("coldStartReq", 1'b1, coldStartReq)
    `CHK("farInReset", 1'b1, farInReset)
    `CHK("userLineOe", d, userLineOe)
    @(posedge clock) pullReset <= 1'b0;
    settle(4);
    `CHK("coldStartReq", 1'b0, coldStartReq)
    settle(2);
    finishTest();
  end
endmodule

/* test/upg_peripheral.sv */
/*
  Far-side equipment on the user port: drives every line the block leaves
  as input, can pull the shared reset line and works the flag pin.
  Assumes the bench steers it through the far* inputs.
*/
`timescale 1ns/100ps

module upg_peripheral (
  input  wire logic [7:0] userLineOut,
  input  wire logic [7:0] userLineOe,
  input  wire logic [7:0] handshakePortOut,
  input  wire logic [7:0] handshakePortOe,
  input  wire logic       resetLineOut,
  input  wire logic       resetLineOe,
  input  wire logic [7:0] farUser,
  input  wire logic [7:0] farHs,
  input  wire logic       pullReset,
  input  wire logic       flagLevel,
  output logic      [7:0] userLineIn,
  output logic      [7:0] handshakePortIn,
  output logic            resetLineIn,
  output logic            flagInput,
  output logic            farInReset
);
  // far side drives only where the block does not, so no line floats
  assign userLineIn      = (userLineOe & userLineOut) | (~userLineOe & farUser);
  assign handshakePortIn = (handshakePortOe & handshakePortOut) |
                           (~handshakePortOe & farHs);
  // open drain with pull-up: low if either party pulls
  assign resetLineIn = !((resetLineOe && !resetLineOut) || pullReset);
  assign farInReset  = !resetLineIn;
  assign flagInput   = flagLevel;
endmodule
